// >>> dv/hcor_cfg_master.sv
// Model of the configuration loader that writes and reads option bytes.
// Assumes the bank samples the loader port on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module hcor_cfg_master (
  // Clock
  input  wire logic       clock,
  // Loader port
  output logic            cfg_we,
  output logic [7:0]      cfg_addr,
  output logic [7:0]      cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  // ==========================================================
  // Idle bus
  initial begin
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
  end

  // ==========================================================
  // Accesses
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_we    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_we    <= 1'b0;
    cfg_wdata <= ~d; // Stale data must not look valid
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    cfg_addr <= a;
    repeat (2) @(posedge clock);
    #1 d = cfg_rdata;
  endtask

  // Hardwired ports are marked before the compound flag goes up
  task automatic declare_compound(input logic [7:0] map, input logic [7:0] oc);
    write_byte(8'h09, map);
    write_byte(8'h07, oc | 8'h08);
  endtask
endmodule

`default_nettype wire

// >>> dv/hcor_opt_bank_test.sv
// Self-checking bench of the option bank, driven through the loader model.
// Assumes shortened filter limits; all inputs change on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module hcor_opt_bank_test;
  import hcor_pkg::*;
  // ==========================================================
  // Signals
  localparam int LIM [4] = '{4, 8, 12, 16};
  logic              clock = 1'b0;
  logic              arst_n;
  logic              cfg_we;
  logic [7:0]        cfg_addr;
  logic [7:0]        cfg_wdata;
  logic [7:0]        cfg_rdata;
  logic              strap_dflt;
  logic [1:0]        straps;
  logic [3:1]        port_dis;
  logic [3:1]        oc_n;
  logic [3:1]        oc_flt;
  logic              compound;
  logic              led_sup;
  logic              speed;
  logic              str_en;
  logic              remap;
  hcor_nport_t       nports;
  logic [3:1]        port_fixed;
  logic [7:0]        desc_rem;
  logic [7:0]        adr [4] = '{8'h07, 8'h08, 8'h09, 8'h0A};
  logic [7:0]        msk [4] = '{8'hB8, 8'h0F, 8'h0E, 8'h00};
  logic [2:0]        exp3;
  int                fails = 0;
  int                samples_checked = 0;
  int                k;

  always #50 clock = ~clock;

  hcor_cfg_master hcor_cfg_master_inst (.clock(clock), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

  hcor_opt_bank #(.OC_CYC_100US(4), .OC_CYC_4MS(8), .OC_CYC_8MS(12), .OC_CYC_16MS(16)) hcor_opt_bank_inst (
    .CLOCK(clock), .ARST_N(arst_n), .CFG_WE(cfg_we), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
    .CFG_RDATA(cfg_rdata), .STRAP_DEFAULT_CFG(strap_dflt), .FIXED_PORT_STRAPS(straps),
    .PORT_DISABLE(port_dis), .OVERCURRENT_N(oc_n), .OVERCURRENT_FILTERED(oc_flt),
    .HUB_COMPOUND(compound), .LED_SUPPORT(led_sup), .SPEED_IND_MODE(speed), .STRING_ENABLE(str_en),
    .PORT_REMAP_ENABLE(remap), .NUM_PORTS(nports), .PORT_FIXED(port_fixed), .DESC_REMOVABLE(desc_rem));

  // ==========================================================
  // Checks and ending
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    hcor_cfg_master_inst.read_byte(a, d);
    samples_checked++;
    if (d !== exp) begin
      fails++;
      $display("mismatch at %0t: got 0x%h expected 0x%h", $time, d, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hcor_cfg_master_inst.write_byte(a, d);
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic complete_run();
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is well under a millisecond
  initial begin
    #1_000_000;
    fails++;
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    arst_n     = 1'b0;
    strap_dflt = 1'b0;
    straps     = 2'h0;
    port_dis   = 3'h0;
    oc_n       = 3'h7;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk_out({5'h0, led_sup, nports}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      chk_reg(adr[i], 8'h00);
      wr(adr[i], 8'hFF);
      chk_reg(adr[i], msk[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, {5'h0, i[1:0], i[2]});
      chk_out({5'h0, speed, led_sup, str_en}, {5'h0, i[1:0] == 2'h1, i[1:0] != 2'h1, i[2]});
    end
    wr(8'h08, 8'h08);
    chk_out({7'h0, remap}, 8'h01);
    wr(8'h08, 8'h00);
    chk_out({7'h0, remap}, 8'h00);
    hcor_cfg_master_inst.declare_compound(8'h0E, 8'h00);
    wr(8'h07, 8'h08);
    chk_out({compound, port_fixed, desc_rem[3:0]}, 8'hFE);
    wr(8'h07, 8'h00);
    chk_out({7'h0, compound}, 8'h00);
    @(posedge clock);
    port_dis <= 3'b010;
    wr(8'h09, 8'h08);
    chk_out({3'h0, nports, port_fixed}, {3'h0, 2'h2, 3'b100});
    chk_out(desc_rem, 8'h04);
    wr(8'h08, 8'h08);
    chk_out(desc_rem, 8'h08);
    @(posedge clock);
    port_dis <= 3'b000;
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h0E);
    @(posedge clock);
    strap_dflt <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      straps <= i[1:0];
      repeat (4) @(posedge clock);
      exp3 = (i == 0) ? 3'b000 : (i == 1) ? 3'b001 : (i == 2) ? 3'b011 : 3'b111;
      #1 chk_out({4'h0, compound, port_fixed}, {4'h0, i != 0, exp3});
    end
    @(posedge clock);
    strap_dflt <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(8'h07, {2'h0, c[1:0], 4'h0});
      @(posedge clock);
      oc_n[1] <= 1'b0;
      k = 0;
      do begin
        @(posedge clock);
        #1 k++;
      end while (oc_flt[1] !== 1'b1 && k < 40);
      chk_out(8'(k), 8'(LIM[c] + 2));
      @(posedge clock);
      oc_n[1] <= 1'b1;
      repeat (4) @(posedge clock);
      #1 chk_out({5'h0, oc_flt}, 8'h00);
    end
    complete_run();
  end
endmodule

`default_nettype wire

// >>> rtl/hcor_flt_if.sv
// Link between the option bank and one over-current filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hcor_params.svh"

interface hcor_flt_if;
  logic                   active;
  logic [`HCOR_CNT_W-1:0] limit;
  logic                   tripped;

  modport ctl (output active, output limit, input tripped);
  modport flt (input active, input limit, output tripped);
endinterface

`default_nettype wire

// >>> rtl/hcor_oc_filter.sv
// One over-current filter: flags a port only after a steady active input.
// Assumes the active input is already synchronised to CLOCK.
`timescale 1ns/1ps
`default_nettype none
`include "hcor_params.svh"

module hcor_oc_filter (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  // Filter link
  hcor_flt_if.flt   fi
);
  import hcor_pkg::*;

  hcor_flt_state_t q;
  hcor_flt_state_t d;

  // ==========================================================
  // Counter
  always_comb begin
    d = q;
    if (!fi.active) begin
      // Any glitch restarts the wait
      d.cnt     = '0;
      d.tripped = 1'b0;
    end else if (q.cnt == fi.limit - hcor_cnt_t'(1)) begin
      d.tripped = 1'b1;
    end else begin
      d.cnt = q.cnt + hcor_cnt_t'(1);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fi.tripped = q.tripped;

  // ==========================================================
  // Checks
  a_trip_after_wait: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(q.tripped) |-> ($past(q.cnt) == fi.limit - hcor_cnt_t'(1)) && $past(fi.active))
    else $error("over-current flag rose before its delay ran out");

  a_trip_release: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !fi.active |=> !q.tripped && (q.cnt == '0))
    else $error("over-current flag held after input went idle");

endmodule

`default_nettype wire

// >>> rtl/hcor_opt_bank.sv
// Hub configuration option bank: option bytes, strap fallback, descriptor bits.
// Assumes a same-clock configuration loader on the CFG port; straps and
// over-current pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "hcor_params.svh"

// How it works
// - Each over-current input must stay active for 0.1, 4, 8 or 16 ms, chosen by the timer code, before it is flagged.
// - The compound bit set to one makes the hub report itself as part of a compound device, and zero does not.
// - Under strap configuration any strapped non-removable port makes the hub report itself as compound.
// - The remap enable bit picks standard port numbering at zero and port remapping at one.
// - Indicator mode code 01 means speed indication and every other code means the USB indication mode.
// - LED support is reported to the host only while the USB indication mode is in force.
// - String descriptors are offered only while the string enable bit is one.
// - Bits 1 to 3 of the fixed port bitmap mark ports 1 to 3 as hardwired when set and removable when clear.
// - Bit 0 of the bitmap always reads zero and bits 7 to 4 mean nothing and hold zero.
// - Under strap configuration the hardwired ports come from the two strap pins, not from the bitmap.
// - The hub tells the host which active ports carry a hardwired device; in remap mode the descriptor bits also mark disabled ports.
// - In standard numbering only enabled ports are counted and they are renumbered without gaps.
module hcor_opt_bank #(
  parameter int OC_CYC_100US = `HCOR_CYC_US(`HCOR_T_100US),
  parameter int OC_CYC_4MS   = `HCOR_CYC_MS(`HCOR_T_4MS),
  parameter int OC_CYC_8MS   = `HCOR_CYC_MS(`HCOR_T_8MS),
  parameter int OC_CYC_16MS  = `HCOR_CYC_MS(`HCOR_T_16MS)
) (
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  ARST_N,
  // Configuration loader
  input  wire logic                  CFG_WE,
  input  wire logic [7:0]            CFG_ADDR,
  input  wire logic [7:0]            CFG_WDATA,
  output logic      [7:0]            CFG_RDATA,
  // Straps
  input  wire logic                  STRAP_DEFAULT_CFG,
  input  wire logic [1:0]            FIXED_PORT_STRAPS,
  // Port state
  input  wire logic [`HCOR_NPORT:1]  PORT_DISABLE,
  input  wire logic [`HCOR_NPORT:1]  OVERCURRENT_N,
  output logic      [`HCOR_NPORT:1]  OVERCURRENT_FILTERED,
  // Reported hub properties
  output logic                       HUB_COMPOUND,
  output logic                       LED_SUPPORT,
  output logic                       SPEED_IND_MODE,
  output logic                       STRING_ENABLE,
  output logic                       PORT_REMAP_ENABLE,
  output hcor_pkg::hcor_nport_t      NUM_PORTS,
  output logic      [`HCOR_NPORT:1]  PORT_FIXED,
  output logic      [7:0]            DESC_REMOVABLE
);
  import hcor_pkg::*;

  hcor_state_t q;
  hcor_state_t d;
  hcor_cnt_t   lim;
  wire logic [2:0] flt_out;

  // ==========================================================
  // Strap decode of the two fixed-port pins
  function automatic logic [2:0] strap_ports(input logic [1:0] s);
    logic [2:0] m;
    m = 3'h0;
    case (s)
      `HCOR_STRAP_NONE: m = 3'h0;
      `HCOR_STRAP_P1:   m = 3'h1;
      `HCOR_STRAP_P12:  m = 3'h3;
      default:          m = 3'h7;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Filter delay select
  always_comb begin
    case (q.oc_opt[`HCOR_TMR_HI:`HCOR_TMR_LO])
      `HCOR_TMR_100US: lim = hcor_cnt_t'(OC_CYC_100US);
      `HCOR_TMR_4MS:   lim = hcor_cnt_t'(OC_CYC_4MS);
      `HCOR_TMR_8MS:   lim = hcor_cnt_t'(OC_CYC_8MS);
      default:         lim = hcor_cnt_t'(OC_CYC_16MS);
    endcase
  end

  // ==========================================================
  // Per-port filters
  for (genvar g = 0; g < `HCOR_NPORT; g++) begin : g_flt
    hcor_flt_if fi ();
    assign fi.active  = ~q.oc_s2[g];
    assign fi.limit   = lim;
    assign flt_out[g] = fi.tripped;
    hcor_oc_filter u_flt (
      .CLOCK  (CLOCK),
      .ARST_N (ARST_N),
      .fi     (fi)
    );
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [2:0]  fixed_eff;
    logic [2:0]  dis;
    logic [7:0]  rem;
    hcor_nport_t cnt;
    fixed_eff = 3'h0;
    dis       = 3'h0;
    rem       = 8'h00;
    cnt       = '0;
    d         = q;

    // Synchronisers; stage one feeds stage two only
    d.strap_s1 = FIXED_PORT_STRAPS;
    d.strap_s2 = q.strap_s1;
    d.src_s1   = STRAP_DEFAULT_CFG;
    d.src_s2   = q.src_s1;
    d.oc_s1    = OVERCURRENT_N;
    d.oc_s2    = q.oc_s1;

    // Option byte writes; reserved bits are masked so they stay zero
    if (CFG_WE) begin
      case (CFG_ADDR)
        `HCOR_ADDR_OC_OPT:  d.oc_opt    = CFG_WDATA & `HCOR_MASK_OC_OPT;
        `HCOR_ADDR_LED_OPT: d.led_opt   = CFG_WDATA & `HCOR_MASK_LED_OPT;
        `HCOR_ADDR_FIXED:   d.fixed_map = CFG_WDATA & `HCOR_MASK_FIXED;
        default:            d.oc_opt    = q.oc_opt;
      endcase
    end

    case (CFG_ADDR)
      `HCOR_ADDR_OC_OPT:  d.rdata = q.oc_opt;
      `HCOR_ADDR_LED_OPT: d.rdata = q.led_opt;
      `HCOR_ADDR_FIXED:   d.rdata = q.fixed_map;
      default:            d.rdata = `HCOR_RD_NONE;
    endcase

    // Strap source overrides the bitmap and the compound flag
    if (q.src_s2) begin
      fixed_eff  = strap_ports(q.strap_s2);
      d.compound = |fixed_eff;
    end else begin
      fixed_eff  = q.fixed_map[`HCOR_FIX_HI:`HCOR_FIX_LO];
      d.compound = q.oc_opt[`HCOR_COMPOUND_BIT];
    end

    d.speed   = (q.led_opt[`HCOR_LED_HI:`HCOR_LED_LO] == `HCOR_LED_SPEED);
    d.led_sup = (q.led_opt[`HCOR_LED_HI:`HCOR_LED_LO] != `HCOR_LED_SPEED);
    d.str_en  = q.led_opt[`HCOR_STRING_BIT];
    d.remap   = q.led_opt[`HCOR_REMAP_BIT];

    // Remap tables live elsewhere, so remap mode keeps physical order here
    dis          = PORT_DISABLE;
    d.fixed_phys = fixed_eff & ~dis;
    if (!q.led_opt[`HCOR_REMAP_BIT]) begin
      for (int p = 0; p < `HCOR_NPORT; p++) begin
        if (!dis[p]) begin
          cnt      = cnt + hcor_nport_t'(1);
          rem[cnt] = fixed_eff[p];
        end
      end
      d.nports = cnt;
    end else begin
      rem      = {4'h0, fixed_eff, 1'b0};
      d.nports = hcor_nport_t'(`HCOR_NPORT);
    end
    d.desc_rem = rem;
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      q           <= '0;
      q.oc_opt    <= `HCOR_RST_OC_OPT;
      q.led_opt   <= `HCOR_RST_LED_OPT;
      q.fixed_map <= `HCOR_RST_FIXED;
      q.oc_s1     <= 3'h7;
      q.oc_s2     <= 3'h7;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign CFG_RDATA            = q.rdata;
  assign OVERCURRENT_FILTERED = flt_out;
  assign HUB_COMPOUND         = q.compound;
  assign LED_SUPPORT          = q.led_sup;
  assign SPEED_IND_MODE       = q.speed;
  assign STRING_ENABLE        = q.str_en;
  assign PORT_REMAP_ENABLE    = q.remap;
  assign NUM_PORTS            = q.nports;
  assign PORT_FIXED           = q.fixed_phys;
  assign DESC_REMOVABLE       = q.desc_rem;

  // ==========================================================
  // Checks
  a_oc_delay_sel: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (q.oc_opt[`HCOR_TMR_HI:`HCOR_TMR_LO] == `HCOR_TMR_4MS) |-> (lim == hcor_cnt_t'(OC_CYC_4MS)))
    else $error("filter delay does not follow the timer code");

  a_compound_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (CFG_WE && CFG_ADDR == `HCOR_ADDR_OC_OPT && !q.src_s2) ##1 !q.src_s2
      |=> (HUB_COMPOUND == $past(CFG_WDATA[`HCOR_COMPOUND_BIT], 2)))
    else $error("compound report does not follow the written bit");

  a_strap_compound: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (q.src_s2 && q.strap_s2 != `HCOR_STRAP_NONE) |=> HUB_COMPOUND)
    else $error("strapped fixed port did not make the hub compound");

  a_led_modes: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (q.led_opt[`HCOR_LED_HI:`HCOR_LED_LO] == `HCOR_LED_SPEED) |=> SPEED_IND_MODE && !LED_SUPPORT)
    else $error("speed indication code decoded wrongly");

  a_led_support: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    LED_SUPPORT |-> !SPEED_IND_MODE && $past(q.led_opt[`HCOR_LED_HI:`HCOR_LED_LO]) != `HCOR_LED_SPEED)
    else $error("LED support reported outside USB indication mode");

  a_string_follow: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    STRING_ENABLE == $past(q.led_opt[`HCOR_STRING_BIT]))
    else $error("string enable does not follow its bit");

  a_remap_follow: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    PORT_REMAP_ENABLE == $past(q.led_opt[`HCOR_REMAP_BIT]))
    else $error("remap enable does not follow its bit");

  a_bitmap_reserved: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (q.fixed_map & ~`HCOR_MASK_FIXED) == 8'h00 && DESC_REMOVABLE[0] == 1'b0)
    else $error("reserved bitmap bit is set");

  a_port_count: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !q.led_opt[`HCOR_REMAP_BIT] |=> NUM_PORTS == hcor_nport_t'(`HCOR_NPORT - $countones($past(PORT_DISABLE))))
    else $error("enabled port count is wrong");

  a_strap_source: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    q.src_s2 |=> PORT_FIXED == (strap_ports($past(q.strap_s2)) & ~$past(PORT_DISABLE)))
    else $error("strap source not used for fixed ports");

endmodule

`default_nettype wire

// >>> rtl/hcor_params.svh
// Constants of the hub configuration option bank: offsets, masks, fields, timing.
// Assumes inclusion by bare name from every file of the block.
`ifndef HCOR_PARAMS_SVH
`define HCOR_PARAMS_SVH

// ==========================================================
// Register offsets and write masks
`define HCOR_ADDR_OC_OPT   8'h07
`define HCOR_ADDR_LED_OPT  8'h08
`define HCOR_ADDR_FIXED    8'h09
`define HCOR_MASK_OC_OPT   8'hB8
`define HCOR_MASK_LED_OPT  8'h0F
`define HCOR_MASK_FIXED    8'h0E
`define HCOR_RST_OC_OPT    8'h00
`define HCOR_RST_LED_OPT   8'h00
`define HCOR_RST_FIXED     8'h00
`define HCOR_RD_NONE       8'h00

// ==========================================================
// Field positions
`define HCOR_TMR_HI        5
`define HCOR_TMR_LO        4
`define HCOR_COMPOUND_BIT  3
`define HCOR_REMAP_BIT     3
`define HCOR_LED_HI        2
`define HCOR_LED_LO        1
`define HCOR_STRING_BIT    0
`define HCOR_FIX_HI        3
`define HCOR_FIX_LO        1

// ==========================================================
// Encodings
`define HCOR_TMR_100US     2'h0
`define HCOR_TMR_4MS       2'h1
`define HCOR_TMR_8MS       2'h2
`define HCOR_TMR_16MS      2'h3
`define HCOR_LED_SPEED     2'h1
`define HCOR_STRAP_NONE    2'h0
`define HCOR_STRAP_P1      2'h1
`define HCOR_STRAP_P12     2'h2
`define HCOR_NPORT         3

// ==========================================================
// Timing
`define HCOR_CLK_MHZ       10
`define HCOR_US_PER_MS     1000
`define HCOR_T_100US       100
`define HCOR_T_4MS         4
`define HCOR_T_8MS         8
`define HCOR_T_16MS        16
`define HCOR_CYC_US(t)     ((t) * `HCOR_CLK_MHZ)
`define HCOR_CYC_MS(t)     ((t) * `HCOR_US_PER_MS * `HCOR_CLK_MHZ)
`define HCOR_CNT_W         18

`endif

// >>> rtl/hcor_pkg.sv
// Types shared by the hub configuration option bank.
// Assumes hcor_params.svh is on the include path.
`include "hcor_params.svh"

package hcor_pkg;

  // ==========================================================
  // Types
  typedef logic [1:0]             hcor_nport_t;
  typedef logic [`HCOR_CNT_W-1:0] hcor_cnt_t;

  typedef struct packed {
    hcor_cnt_t cnt;
    logic      tripped;
  } hcor_flt_state_t;

  typedef struct packed {
    logic [7:0]  oc_opt;
    logic [7:0]  led_opt;
    logic [7:0]  fixed_map;
    logic [1:0]  strap_s1;
    logic [1:0]  strap_s2;
    logic        src_s1;
    logic        src_s2;
    logic [2:0]  oc_s1;
    logic [2:0]  oc_s2;
    logic [7:0]  rdata;
    logic        compound;
    logic        led_sup;
    logic        speed;
    logic        str_en;
    logic        remap;
    hcor_nport_t nports;
    logic [2:0]  fixed_phys;
    logic [7:0]  desc_rem;
  } hcor_state_t;

endpackage
